// ===== pmc_pkg.sv
// package: register map, field positions and states of the power mode controller
package pmc_pkg;

  // register byte addresses on the axi4-lite slave
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;

  // control register field positions
  localparam int BIT_PSM   = 0;
  localparam int BIT_IDLE  = 1;
  localparam int BIT_HALT  = 2;
  localparam int BIT_WBLP  = 3;
  localparam int BIT_DMO   = 4;
  localparam int BIT_DPLL  = 5;

  // status register field positions
  localparam int BIT_LFS   = 0;
  localparam int BIT_MCS   = 1;
  localparam int BIT_PLS   = 2;

  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // power modes, gray coded along active -> low power -> wake path
  typedef enum logic [2:0] {
    PMC_ACTIVE    = 3'b000,
    PMC_ENTER_PS  = 3'b001,
    PMC_PSAVE     = 3'b011,
    PMC_IDLE      = 3'b010,
    PMC_HALT      = 3'b110,
    PMC_WAKE_OSC  = 3'b111,
    PMC_WAKE_PLL  = 3'b101,
    PMC_EXIT_PS   = 3'b100
  } pmc_state_t;

  // control register image
  typedef struct packed {
    logic [1:0] rsvd;
    logic       pll_disable;
    logic       main_osc_disable;
    logic       wait_before_low_power;
    logic       halt_request;
    logic       idle_request;
    logic       power_save_request;
  } pmc_control_t;

  // clock outputs toward prescalers, pll and oscillator
  typedef struct packed {
    logic sys_clk_enable;
    logic slow_clk_select;
    logic slow_clk_enable;
    logic main_osc_enable;
    logic pll_enable;
  } pmc_clock_t;

endpackage

// ===== pmc_power_mode_controller.sv
// power mode controller with axi4-lite register slave
// Behaviour
// - with power-save and wait bits clear, writing power-save starts immediate switch
// - with wait bit set, power-save entry waits for wait instruction
// - immediate switch: power-save bit reads set only after switch completes
// - deferred switch: power-save bit reads set as soon as written
// - software clears power-save bit; wake-up clears it too
// - idle needs wait bit; idle entered at next wait instruction
// - idle bit set and cleared by software, cleared on wake-up
// - halt needs wait bit; halt entered at next wait instruction
// - halt entry stops system clock first, then pll and oscillator
// - halt wake restarts oscillator, clears halt bit once it is stable
// - with wait bit set, disable bits act only after low power entered
// - oscillator disable bit 4 acts only in power save and idle modes
// - pll disable bit 5 gates pll in power save, with pll power-down
// - wake-up clears oscillator disable and pll disable bits
// - control register non-reserved bits clear at reset
// - low-freq stable flag bit 0; low power refused while clear
// - main clock stable flag bit 1; active switch waits for it
// - pll stable flag bit 2 reads 1 when disabled; active waits
// - status flags show live clocks; upper five status bits zero
// - wake-up latched until interrupt acknowledge or reset; no code start
// - idle and halt only entered from active mode
// - wake: clear osc disable, wait stable, clear pll disable, wait, active
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_controller (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // axi4-lite write address and data
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // axi4-lite read
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // cpu and wake sources
  input  wire logic                 wait_executed,
  input  wire logic                 wake_request,
  input  wire logic                 nmi_request,
  input  wire logic                 int_acknowledge,
  // clock source status and pll power-down
  input  wire logic                 low_freq_clock_stable,
  input  wire logic                 main_osc_stable,
  input  wire logic                 pll_locked,
  input  wire logic                 pll_power_down,
  // clock gating outputs and mode
  output pmc_pkg::pmc_clock_t       clock_ctrl,
  output pmc_pkg::pmc_state_t       power_mode
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  pmc_pkg::pmc_control_t ctrl;
  pmc_pkg::pmc_control_t next_ctrl;
  pmc_pkg::pmc_state_t   state;
  pmc_pkg::pmc_state_t   next_state;
  logic                  wake_latched;
  logic                  next_wake_latched;
  logic                  ps_pending;
  logic                  next_ps_pending;
  pmc_pkg::pmc_clock_t   next_clock_ctrl;
  logic                  aw_held;
  logic                  next_aw_held;
  logic                  w_held;
  logic                  next_w_held;
  logic [3:0]            aw_addr;
  logic [3:0]            next_aw_addr;
  logic [7:0]            w_byte;
  logic [7:0]            next_w_byte;
  logic                  w_lane0;
  logic                  next_w_lane0;
  logic                  next_bvalid;
  logic [1:0]            next_bresp;
  logic                  next_rvalid;
  logic [31:0]           next_rdata;
  logic [1:0]            next_rresp;
  logic                  pll_ok;
  logic                  do_write;
  logic                  wake_event;
  logic [7:0]            status_byte;

  // pll flag counts as good when the pll is disabled
  function automatic logic pll_stable_flag(input logic locked, input logic enabled);
    pll_stable_flag = locked | ~enabled;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // status and bus decode
  always_comb begin
    pll_ok      = pll_stable_flag(pll_locked, clock_ctrl.pll_enable);
    status_byte = {5'h00, pll_ok, main_osc_stable, low_freq_clock_stable};
    do_write    = aw_held && w_held && !s_axi_bvalid;
    // latched wake stays set until acknowledge
    wake_event  = wake_latched | wake_request | nmi_request;
  end

  // bus channel bookkeeping; address and data may arrive in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (aw_addr == pmc_pkg::ADDR_CONTROL || aw_addr == pmc_pkg::ADDR_STATUS) begin
        next_bresp = pmc_pkg::RESP_OKAY;
      end else begin
        next_bresp = pmc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = pmc_pkg::RESP_OKAY;
      if (s_axi_araddr == pmc_pkg::ADDR_CONTROL) begin
        next_rdata = {24'h00_0000, ctrl};
      end else if (s_axi_araddr == pmc_pkg::ADDR_STATUS) begin
        next_rdata = {24'h00_0000, status_byte};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = pmc_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register and mode sequencer
  always_comb begin
    next_ctrl         = ctrl;
    next_state        = state;
    next_ps_pending   = ps_pending;
    next_wake_latched = wake_latched;
    // software write of the control byte
    if (do_write && w_lane0 && aw_addr == pmc_pkg::ADDR_CONTROL) begin
      next_ctrl.rsvd                  = 2'b00;
      next_ctrl.wait_before_low_power = w_byte[pmc_pkg::BIT_WBLP];
      next_ctrl.idle_request          = w_byte[pmc_pkg::BIT_IDLE];
      next_ctrl.halt_request          = w_byte[pmc_pkg::BIT_HALT];
      // disable bits are only consulted in power save, idle and wake-osc states below
      next_ctrl.main_osc_disable      = w_byte[pmc_pkg::BIT_DMO];
      next_ctrl.pll_disable           = w_byte[pmc_pkg::BIT_DPLL];
      if (w_byte[pmc_pkg::BIT_PSM]) begin
        if (ctrl.wait_before_low_power) begin
          // deferred: bit reads set at once
          next_ctrl.power_save_request = 1'b1;
        end else if (!ctrl.power_save_request && state == pmc_pkg::PMC_ACTIVE) begin
          // immediate start, bit stays clear for now
          next_ps_pending = 1'b1;
        end
      end else begin
        // software clear; leaving power save handled below
        next_ctrl.power_save_request = 1'b0;
        next_ps_pending              = 1'b0;
      end
    end
    if (wake_request || nmi_request) begin
      next_wake_latched = 1'b1;
    end else if (int_acknowledge) begin
      next_wake_latched = 1'b0;
    end
    case (state)
      pmc_pkg::PMC_ACTIVE: begin
        // refuse low power while the slow oscillator is not stable
        if (low_freq_clock_stable && !wake_event) begin
          if (ps_pending) begin
            next_state = pmc_pkg::PMC_ENTER_PS;
          end else if (wait_executed && ctrl.wait_before_low_power) begin
            // one request per wait, halt over idle over power save
            if (ctrl.halt_request) begin
              // halt at wait; only from active
              next_state = pmc_pkg::PMC_HALT;
            end else if (ctrl.idle_request) begin
              next_state = pmc_pkg::PMC_IDLE;
            end else if (ctrl.power_save_request) begin
              next_state = pmc_pkg::PMC_PSAVE;
            end
          end
        end
      end
      pmc_pkg::PMC_ENTER_PS: begin
        // bit set once the switch has completed
        next_state                   = pmc_pkg::PMC_PSAVE;
        next_ctrl.power_save_request = 1'b1;
        next_ps_pending              = 1'b0;
      end
      pmc_pkg::PMC_PSAVE: begin
        if (wake_event) begin
          // wake clears request and oscillator disable bits
          next_ctrl.power_save_request = 1'b0;
          next_ctrl.main_osc_disable   = 1'b0;
          next_state                   = pmc_pkg::PMC_WAKE_OSC;
        end else if (!next_ctrl.power_save_request) begin
          // software exit still waits for the clocks
          next_state = pmc_pkg::PMC_EXIT_PS;
        end
      end
      pmc_pkg::PMC_IDLE, pmc_pkg::PMC_HALT: begin
        if (wake_event) begin
          // idle bit cleared on wake; osc disable cleared
          next_ctrl.idle_request     = 1'b0;
          next_ctrl.main_osc_disable = 1'b0;
          next_ctrl.power_save_request = 1'b0;
          next_state                 = pmc_pkg::PMC_WAKE_OSC;
        end
      end
      pmc_pkg::PMC_WAKE_OSC: begin
        // step 2 and wait main clock, then release pll
        if (main_osc_stable) begin
          // halt bit cleared only once oscillator is stable
          next_ctrl.halt_request = 1'b0;
          next_ctrl.pll_disable  = 1'b0;
          next_state             = pmc_pkg::PMC_WAKE_PLL;
        end
      end
      pmc_pkg::PMC_WAKE_PLL: begin
        if (pll_ok) begin
          next_state = pmc_pkg::PMC_ACTIVE;
        end
      end
      pmc_pkg::PMC_EXIT_PS: begin
        // clocks must be good before active
        if (main_osc_stable && pll_ok) begin
          next_state = pmc_pkg::PMC_ACTIVE;
        end
      end
      default: begin
        next_state = pmc_pkg::PMC_ACTIVE;
      end
    endcase
  end

  // clock gating follows the next mode so outputs stay registered
  always_comb begin
    next_clock_ctrl.sys_clk_enable  = 1'b1;
    next_clock_ctrl.slow_clk_select = 1'b0;
    next_clock_ctrl.slow_clk_enable = 1'b1;
    next_clock_ctrl.main_osc_enable = 1'b1;
    next_clock_ctrl.pll_enable      = !pll_power_down;
    case (next_state)
      pmc_pkg::PMC_PSAVE: begin
        next_clock_ctrl.slow_clk_select = 1'b1;
        // oscillator gated by its disable bit here and in idle
        next_clock_ctrl.main_osc_enable = !next_ctrl.main_osc_disable;
        // pll gated by its disable and power-down
        next_clock_ctrl.pll_enable      = !next_ctrl.pll_disable && !pll_power_down;
      end
      pmc_pkg::PMC_ENTER_PS, pmc_pkg::PMC_EXIT_PS: begin
        next_clock_ctrl.slow_clk_select = 1'b1;
      end
      pmc_pkg::PMC_IDLE: begin
        next_clock_ctrl.sys_clk_enable  = 1'b0;
        next_clock_ctrl.main_osc_enable = !next_ctrl.main_osc_disable;
        next_clock_ctrl.pll_enable      = !next_ctrl.pll_disable && !pll_power_down;
      end
      pmc_pkg::PMC_HALT: begin
        // system clock stops on entry; sources drop the cycle after
        next_clock_ctrl.sys_clk_enable  = 1'b0;
        next_clock_ctrl.slow_clk_enable = 1'b0;
        next_clock_ctrl.main_osc_enable = (state != pmc_pkg::PMC_HALT);
        next_clock_ctrl.pll_enable      = (state != pmc_pkg::PMC_HALT) && !pll_power_down;
      end
      pmc_pkg::PMC_WAKE_OSC: begin
        next_clock_ctrl.sys_clk_enable  = 1'b0;
        next_clock_ctrl.pll_enable      = !next_ctrl.pll_disable && !pll_power_down;
      end
      pmc_pkg::PMC_WAKE_PLL: begin
        next_clock_ctrl.sys_clk_enable  = 1'b0;
      end
      default: begin
        next_clock_ctrl.sys_clk_enable  = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl          <= pmc_pkg::CONTROL_RESET;
      state         <= pmc_pkg::PMC_ACTIVE;
      ps_pending    <= 1'b0;
      wake_latched  <= 1'b0;
      clock_ctrl    <= 5'h17;
      aw_held       <= 1'b0;
      aw_addr       <= 4'h0;
      w_held        <= 1'b0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pmc_pkg::RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pmc_pkg::RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      power_mode    <= pmc_pkg::PMC_ACTIVE;
    end else begin
      ctrl          <= next_ctrl;
      state         <= next_state;
      ps_pending    <= next_ps_pending;
      wake_latched  <= next_wake_latched;
      clock_ctrl    <= next_clock_ctrl;
      aw_held       <= next_aw_held;
      aw_addr       <= next_aw_addr;
      w_held        <= next_w_held;
      w_byte        <= next_w_byte;
      w_lane0       <= next_w_lane0;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
      // ready for one cycle at a time, only while that channel has nothing held
      s_axi_awready <= !next_aw_held && !s_axi_awready;
      s_axi_wready  <= !next_w_held && !s_axi_wready;
      s_axi_arready <= !next_rvalid && !s_axi_arready;
      power_mode    <= next_state;
    end
  end

endmodule
`default_nettype wire

// ===== pmc_mode_asserts.sv
// checker: mode sequencing and clock gating of the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_mode_asserts (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // cpu, wake sources and clock status
  input  wire logic                wait_executed,
  input  wire logic                wake_request,
  input  wire logic                nmi_request,
  input  wire logic                low_freq_clock_stable,
  input  wire logic                main_osc_stable,
  input  wire logic                pll_locked,
  // gating and mode
  input  wire pmc_pkg::pmc_clock_t clock_ctrl,
  input  wire pmc_pkg::pmc_state_t power_mode
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // halt entry: system clock stops first, sources one cycle on
  sequence s_halt_entry;
    $changed(power_mode) && power_mode == pmc_pkg::PMC_HALT;
  endsequence
  // a wake in the first halt cycle may restart the oscillator
  sequence s_clocks_down;
    !clock_ctrl.sys_clk_enable && clock_ctrl.main_osc_enable
    ##1 (power_mode != pmc_pkg::PMC_HALT || !(clock_ctrl.main_osc_enable || clock_ctrl.pll_enable));
  endsequence
  ////////////////////////////////////////////////////////////////
  a_reset_mode_clocks: assert property ($fell(rst) |-> power_mode == pmc_pkg::PMC_ACTIVE && clock_ctrl == 5'h17)
    else $error("mode or clock gating wrong after reset");
  a_active_osc_on: assert property (power_mode == pmc_pkg::PMC_ACTIVE |-> clock_ctrl.main_osc_enable)
    else $error("oscillator off in active mode");
  a_lowfreq_blocks_entry: assert property (power_mode == pmc_pkg::PMC_ACTIVE && !low_freq_clock_stable
    |=> power_mode == pmc_pkg::PMC_ACTIVE)
    else $error("left active mode with slow clock unstable");
  a_halt_clock_order: assert property (s_halt_entry |-> s_clocks_down)
    else $error("halt entry clock order wrong");
  a_osc_before_pll: assert property (power_mode == pmc_pkg::PMC_WAKE_OSC && !main_osc_stable
    |=> power_mode == pmc_pkg::PMC_WAKE_OSC)
    else $error("wake went on before oscillator stable");
  a_pll_gates_active: assert property (power_mode == pmc_pkg::PMC_WAKE_PLL && clock_ctrl.pll_enable && !pll_locked
    |=> power_mode == pmc_pkg::PMC_WAKE_PLL)
    else $error("active reached with pll unstable");
  a_wake_leaves_low: assert property ((wake_request || nmi_request)
    && power_mode inside {pmc_pkg::PMC_PSAVE, pmc_pkg::PMC_IDLE, pmc_pkg::PMC_HALT}
    |=> power_mode == pmc_pkg::PMC_WAKE_OSC)
    else $error("wake event did not start wake sequence");
  a_wait_gates_entry: assert property (power_mode == pmc_pkg::PMC_ACTIVE && !wait_executed
    |=> power_mode inside {pmc_pkg::PMC_ACTIVE, pmc_pkg::PMC_ENTER_PS})
    else $error("idle or halt entered without wait");
  a_low_from_active: assert property ($changed(power_mode)
    && power_mode inside {pmc_pkg::PMC_IDLE, pmc_pkg::PMC_HALT}
    |-> $past(power_mode) == pmc_pkg::PMC_ACTIVE)
    else $error("idle or halt entered from other mode");
endmodule
bind pmc_power_mode_controller pmc_mode_asserts u_mode_asserts (
  .ref_clk(ref_clk), .rst(rst), .wait_executed(wait_executed), .wake_request(wake_request),
  .nmi_request(nmi_request), .low_freq_clock_stable(low_freq_clock_stable), .main_osc_stable(main_osc_stable),
  .pll_locked(pll_locked), .clock_ctrl(clock_ctrl), .power_mode(power_mode)
);
`default_nettype wire

// ===== pmc_clock_model.sv
// far-side model: oscillators and pll with start-up delays
`timescale 1ns/10ps
`default_nettype none
module pmc_clock_model #(
  parameter int LF_DLY  = 40,
  parameter int OSC_DLY = 4,
  parameter int PLL_DLY = 3
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst,
  // gating from the controller
  input  wire pmc_pkg::pmc_clock_t clock_ctrl,
  // stability toward the controller
  output logic                     low_freq_clock_stable,
  output logic                     main_osc_stable,
  output logic                     pll_locked
);
  int lf_cnt  = 0;
  int osc_cnt = 0;
  int pll_cnt = 0;
  ////////////////////////////////////////////////////////////////
  // start-up counters; a disabled oscillator or pll loses stability at once, low-freq only at reset
  always_ff @(posedge ref_clk) begin
    lf_cnt  <= rst ? 0 : (lf_cnt < LF_DLY ? lf_cnt + 1 : lf_cnt);
    osc_cnt <= clock_ctrl.main_osc_enable !== 1'b1 ? 0 : (osc_cnt < OSC_DLY ? osc_cnt + 1 : osc_cnt);
    pll_cnt <= clock_ctrl.pll_enable !== 1'b1 ? 0 : (pll_cnt < PLL_DLY ? pll_cnt + 1 : pll_cnt);
  end
  // stable only once the full start-up time has run
  assign low_freq_clock_stable = (lf_cnt == LF_DLY);
  assign main_osc_stable       = (osc_cnt == OSC_DLY);
  assign pll_locked            = (pll_cnt == PLL_DLY);
endmodule
`default_nettype wire

// ===== pmc_power_mode_controller_tb_top.sv
// testbench: register access and mode sequencing of the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_power_mode_controller_tb_top;
  logic                ref_clk = 1'b0;
  logic                rst = 1'b1;
  logic [3:0]          awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, ev = 4'h0;
  logic [31:0]         wdata = 32'h0000_0000;
  logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic                awready, wready, bvalid, arready, rvalid, lf, mc, pl;
  logic                pd = 1'b0;
  logic [1:0]          bresp, rresp;
  logic [31:0]         rdata;
  pmc_pkg::pmc_clock_t clk_ctrl;
  pmc_pkg::pmc_state_t mode;
  int                  n_errors = 0, compares = 0;
  ////////////////////////////////////////////////////////////////
  // 25 mhz reference clock
  always #20 ref_clk = ~ref_clk;
  // ev bits: wait, wake input, nmi, interrupt acknowledge
  pmc_power_mode_controller i_dut (
    .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_executed(ev[0]), .wake_request(ev[1]),
    .nmi_request(ev[2]), .int_acknowledge(ev[3]), .low_freq_clock_stable(lf), .main_osc_stable(mc),
    .pll_locked(pl), .pll_power_down(pd), .clock_ctrl(clk_ctrl), .power_mode(mode));
  pmc_clock_model i_clocks (
    .ref_clk(ref_clk), .rst(rst), .clock_ctrl(clk_ctrl), .low_freq_clock_stable(lf), .main_osc_stable(mc),
    .pll_locked(pl));
  ////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out;
    if (n_errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one clock under a shared bound, so no wait can hang
  task automatic step(inout int n);
    @(posedge ref_clk);
    n++;
    if (n > 400) begin
      n_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out;
    end
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic mode_is(input pmc_pkg::pmc_state_t m);
    chk({29'h0, mode}, {29'h0, m});
  endtask
  // polls stay bounded through step
  task automatic wait_mode(input pmc_pkg::pmc_state_t m);
    int n;
    n = 0;
    while (mode !== m) step(n);
    compares++;
  endtask
  task automatic wait_gate(input logic [1:0] v);
    int n;
    n = 0;
    while ({clk_ctrl.main_osc_enable, clk_ctrl.pll_enable} !== v) step(n);
    compares++;
  endtask
  task automatic pulse(input logic [3:0] p);
    ev <= p;
    @(posedge ref_clk);
    ev <= 4'h0;
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////
  // axi4-lite write: address and data offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      step(n);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (!bvalid) step(n);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
    // one idle edge so a following call never re-drives bready in this step
    @(posedge ref_clk);
  endtask
  // axi4-lite read: data and response taken at the rvalid edge
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do step(n); while (!arready);
    arvalid <= 1'b0;
    do step(n); while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h00_0000, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [31:0] rv;
    logic [1:0]  rr;
    int          k;
    rv = 32'h0000_0000;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rc(4'h0, 8'h00, pmc_pkg::RESP_OKAY);
    rc(4'h4, 8'h06, pmc_pkg::RESP_OKAY);
    wr(4'h0, 8'h31, pmc_pkg::RESP_OKAY);
    repeat (8) @(posedge ref_clk);
    mode_is(pmc_pkg::PMC_ACTIVE);
    wait_gate(2'b11);
    for (k = 0; k < 60 && rv[0] !== 1'b1; k++) rd(4'h4, rv, rr);
    chk({31'h0, rv[0]}, 32'h0000_0001);
    wait_mode(pmc_pkg::PMC_PSAVE);
    chk({27'h0, clk_ctrl}, 32'h0000_001c);
    rc(4'h0, 8'h31, pmc_pkg::RESP_OKAY);
    wait_gate(2'b00);
    pulse(4'h2);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rc(4'h0, 8'h00, pmc_pkg::RESP_OKAY);
    rc(4'hc, 8'h00, pmc_pkg::RESP_SLVERR);
    wr(4'h4, 8'hff, pmc_pkg::RESP_OKAY);
    wr(4'h8, 8'h01, pmc_pkg::RESP_SLVERR);
    rc(4'h4, 8'h07, pmc_pkg::RESP_OKAY);
    pd <= 1'b1;
    wait_gate(2'b10);
    rc(4'h4, 8'h07, pmc_pkg::RESP_OKAY);
    pd <= 1'b0;
    wait_gate(2'b11);
    wr(4'h0, 8'h3a, pmc_pkg::RESP_OKAY);
    rc(4'h0, 8'h3a, pmc_pkg::RESP_OKAY);
    chk({30'h0, clk_ctrl.main_osc_enable, clk_ctrl.pll_enable}, 32'h0000_0003);
    pulse(4'h1);
    repeat (4) @(posedge ref_clk);
    mode_is(pmc_pkg::PMC_ACTIVE);
    pulse(4'h8);
    pulse(4'h1);
    wait_mode(pmc_pkg::PMC_IDLE);
    chk({27'h0, clk_ctrl}, 32'h0000_0004);
    pulse(4'h4);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rc(4'h0, 8'h08, pmc_pkg::RESP_OKAY);
    pulse(4'h8);
    wr(4'h0, 8'h3f, pmc_pkg::RESP_OKAY);
    pulse(4'h1);
    wait_mode(pmc_pkg::PMC_HALT);
    chk({27'h0, clk_ctrl}, 32'h0000_0003);
    wait_gate(2'b00);
    pulse(4'h2);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rc(4'h0, 8'h08, pmc_pkg::RESP_OKAY);
    pulse(4'h8);
    wr(4'h0, 8'h09, pmc_pkg::RESP_OKAY);
    rc(4'h0, 8'h09, pmc_pkg::RESP_OKAY);
    mode_is(pmc_pkg::PMC_ACTIVE);
    pulse(4'h1);
    wait_mode(pmc_pkg::PMC_PSAVE);
    wr(4'h0, 8'h0b, pmc_pkg::RESP_OKAY);
    pulse(4'h1);
    repeat (4) @(posedge ref_clk);
    mode_is(pmc_pkg::PMC_PSAVE);
    wr(4'h0, 8'h08, pmc_pkg::RESP_OKAY);
    wait_mode(pmc_pkg::PMC_ACTIVE);
    rc(4'h0, 8'h08, pmc_pkg::RESP_OKAY);
    close_out;
  end
endmodule
`default_nettype wire
